// >>> src/eeprom_pkg.sv
// Shared constants and types for the two-wire EEPROM target and its controller
// Functional notes
// - START then STOP aborts command entry
// - No abort possible while target pulls SDA
// - Controller recovers stuck SDA with software reset
// - Read abort leaves address pointer undefined
// - After read abort, use random read
// - Strap inputs must match address byte bits
// - Guard high blocks every memory write
// - Guard low allows reads, and allows writes while lockout is low
// - Controller drives SDA, SCL high at power-up
// - Controller issues software reset after power-up
// - Acknowledge after START and matching address
// - Controller releases SDA during dummy clocks
package eeprom_pkg;
	// Memory organisation
	localparam logic [3:0] DEVICE_TYPE_CODE = 4'hA;
	localparam int         MEM_WORDS        = 256;
	localparam int         PAGE_WORDS       = 8;
	localparam logic [7:0] MEM_RESET_VALUE  = 8'hFF;
	// Timing
	localparam int CLOCK_PERIOD_NS    = 8;
	localparam int WRITE_CYCLE_NS     = 5000000;
	localparam int WRITE_CYCLE_CYCLES = (WRITE_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int SCL_PERIOD_NS      = 10000;
	localparam int QUARTER_CYCLES     = SCL_PERIOD_NS / (4 * CLOCK_PERIOD_NS);
	localparam int POWERUP_HOLD_NS    = 1000;
	localparam int POWERUP_CYCLES     = (POWERUP_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	// Target input synchroniser idle value: {lockout, guard, strap2..0, sda, scl}
	localparam logic [6:0] TARGET_SYNC_RESET = 7'h03;
	// Controller register map and fields
	localparam logic [3:0] REG_COMMAND    = 4'h0;
	localparam logic [3:0] REG_STATUS     = 4'h4;
	localparam int         CMD_OP_LSB     = 0;
	localparam int         CMD_TX_LSB     = 8;
	localparam int         CMD_NAK_BIT    = 16;
	localparam int         STAT_BUSY_BIT  = 0;
	localparam int         STAT_ACK_BIT   = 1;
	localparam int         STAT_STALE_BIT = 2;
	localparam int         STAT_RX_LSB    = 8;
	// Controller bus operations
	typedef enum logic [2:0] {
		OP_NONE    = 3'h0,
		OP_START   = 3'h1,
		OP_STOP    = 3'h2,
		OP_WRITE   = 3'h3,
		OP_READ    = 3'h4,
		OP_ABORT   = 3'h5,
		OP_SWRESET = 3'h6
	} host_op_t;
endpackage : eeprom_pkg

// >>> src/i2c_if.sv
// Two-wire bus carrier joining controller and target, with wired-AND resolution on SDA
`timescale 1ns/1ps
interface i2c_if;
	logic sclOut;
	logic sclOe;
	logic hostSdaOut;
	logic hostSdaOe;
	logic devSdaOut;
	logic devSdaOe;
	logic sclLine;
	logic sdaLine;

	// Pull-ups win unless someone drives low
	assign sclLine = sclOe ? sclOut : 1'b1;
	assign sdaLine = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));

	modport device (input sclLine, input sdaLine, output devSdaOut, output devSdaOe);
	modport host (input sclLine, input sdaLine, output sclOut, output sclOe,
		output hostSdaOut, output hostSdaOe);
endinterface : i2c_if

// >>> src/eeprom_target.sv
// Two-wire EEPROM target: address match, page write, reads, abort and write guard
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module eeprom_target
	import eeprom_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYCLE_CYCLES
)
(
	input  wire logic clock,
	input  wire logic arst_n,
	i2c_if.device     bus,
	input  wire logic chipSelectStrapBit0,
	input  wire logic chipSelectStrapBit1,
	input  wire logic chipSelectStrapBit2,
	input  wire logic writeGuard,
	input  wire logic lowSupplyWriteLockout,
	output logic      writeBusy,
	output logic      pointerDefined
);
	typedef enum logic [2:0] {
		D_IDLE  = 3'h0,
		D_ADDR  = 3'h1,
		D_WORD  = 3'h2,
		D_DATA  = 3'h3,
		D_ACK   = 3'h4,
		D_READ  = 3'h5,
		D_RACK  = 3'h6,
		D_RLOAD = 3'h7
	} dev_state_t;

	generate
		if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << 20))
		begin : gBadWriteCycles
			$error("WRITE_CYCLES out of range");
		end
	endgenerate

	logic [6:0]  sync1_q;
	logic [6:0]  sync2_q;
	logic        sclPrev_q;
	logic        sdaPrev_q;
	dev_state_t  state_q;
	dev_state_t  state_d;
	dev_state_t  next_q;
	dev_state_t  next_d;
	logic        waitStop_q;
	logic        waitStop_d;
	logic [3:0]  bitCnt_q;
	logic [3:0]  bitCnt_d;
	logic [7:0]  shift_q;
	logic [7:0]  shift_d;
	logic        sdaLow_q;
	logic        sdaLow_d;
	logic [7:0]  ptr_q;
	logic [7:0]  ptr_d;
	logic        ptrDef_q;
	logic        ptrDef_d;
	logic        readLike_q;
	logic        readLike_d;
	logic [19:0] busyCnt_q;
	logic [19:0] busyCnt_d;
	logic [7:0]  page_q [PAGE_WORDS];
	logic [7:0]  page_d [PAGE_WORDS];
	logic [7:0]  pageMask_q;
	logic [7:0]  pageMask_d;
	logic [7:0]  mem_q [MEM_WORDS];
	logic [7:0]  mem_d [MEM_WORDS];
	logic        scl;
	logic        sda;
	logic [2:0]  strap;
	logic        guard;
	logic        lockout;
	logic        sclRise;
	logic        sclFall;
	logic        startCond;
	logic        stopCond;

	// Two-flop synchronisers on every pin input
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_q   <= TARGET_SYNC_RESET;
			sync2_q   <= TARGET_SYNC_RESET;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end
		else
		begin
			sync1_q   <= {lowSupplyWriteLockout, writeGuard, chipSelectStrapBit2,
				chipSelectStrapBit1, chipSelectStrapBit0, bus.sdaLine, bus.sclLine};
			sync2_q   <= sync1_q;
			sclPrev_q <= sync2_q[0];
			sdaPrev_q <= sync2_q[1];
		end
	end

	// Bus events from the settled levels
	assign scl     = sync2_q[0];
	assign sda     = sync2_q[1];
	assign strap   = sync2_q[4:2];
	assign guard   = sync2_q[5];
	assign lockout = sync2_q[6];
	assign sclRise = scl & ~sclPrev_q;
	assign sclFall = ~scl & sclPrev_q;
	// Our own low drive masks the line, so no START or STOP is seen then
	assign startCond = scl & sclPrev_q & sdaPrev_q & ~sda & ~sdaLow_q;
	assign stopCond  = scl & sclPrev_q & ~sdaPrev_q & sda & ~sdaLow_q;

	// Protocol engine, page buffer and array update
	always_comb
	begin
		state_d    = state_q;
		next_d     = next_q;
		waitStop_d = waitStop_q;
		bitCnt_d   = bitCnt_q;
		shift_d    = shift_q;
		sdaLow_d   = sdaLow_q;
		ptr_d      = ptr_q;
		ptrDef_d   = ptrDef_q;
		readLike_d = readLike_q;
		busyCnt_d  = busyCnt_q;
		page_d     = page_q;
		pageMask_d = pageMask_q;
		mem_d      = mem_q;
		if (busyCnt_q != 20'h00000)
			busyCnt_d = busyCnt_q - 20'h00001;
		if (startCond)
		begin
			state_d    = D_ADDR;
			waitStop_d = 1'b0;
			bitCnt_d   = 4'h0;
		end
		else if (stopCond)
		begin
			state_d    = D_IDLE;
			waitStop_d = 1'b0;
			pageMask_d = 8'h00;
			readLike_d = 1'b0;
			// START then STOP while the address is being entered cancels it
			if (state_q == D_ADDR)
			begin
				if (readLike_q)
					ptrDef_d = 1'b0;
			end
			else if (pageMask_q != 8'h00 && !guard && !lockout)
			begin
				// Commit the page, then ignore the bus for the write cycle
				for (int i = 0; i < PAGE_WORDS; i++)
					if (pageMask_q[i])
						mem_d[{ptr_q[7:3], 3'(i)}] = page_q[i];
				busyCnt_d = 20'(WRITE_CYCLES);
			end
		end
		else if (!waitStop_q)
		begin
			case (state_q)
				D_ADDR, D_WORD, D_DATA:
				begin
					if (sclRise && bitCnt_q != 4'h8)
					begin
						shift_d  = {shift_q[6:0], sda};
						bitCnt_d = bitCnt_q + 4'h1;
					end
					else if (sclFall && bitCnt_q == 4'h8)
					begin
						sdaLow_d = 1'b1;
						state_d  = D_ACK;
						next_d   = D_DATA;
						if (state_q == D_ADDR)
						begin
							// Busy array or foreign address: stay silent
							if (shift_q[7:4] == DEVICE_TYPE_CODE && shift_q[3:1] == strap
								&& busyCnt_q == 20'h00000)
							begin
								next_d     = shift_q[0] ? D_RLOAD : D_WORD;
								readLike_d = readLike_q | shift_q[0];
							end
							else
							begin
								sdaLow_d   = 1'b0;
								waitStop_d = 1'b1;
							end
						end
						else if (state_q == D_WORD)
						begin
							ptr_d      = shift_q;
							ptrDef_d   = 1'b1;
							readLike_d = 1'b1;
						end
						else if (!guard)
						begin
							page_d[ptr_q[2:0]]     = shift_q;
							pageMask_d[ptr_q[2:0]] = 1'b1;
							ptr_d = {ptr_q[7:3], ptr_q[2:0] + 3'h1};
							readLike_d = 1'b0;
						end
					end
				end
				D_ACK, D_RLOAD:
				begin
					if (sclFall)
					begin
						bitCnt_d = 4'h0;
						sdaLow_d = 1'b0;
						state_d  = next_q;
						if (state_q == D_RLOAD || next_q == D_RLOAD)
						begin
							shift_d  = mem_q[ptr_q];
							sdaLow_d = ~mem_q[ptr_q][7];
							state_d  = D_READ;
						end
					end
				end
				D_READ:
				begin
					if (sclFall)
					begin
						if (bitCnt_q == 4'h7)
						begin
							sdaLow_d = 1'b0;
							state_d  = D_RACK;
							ptr_d    = ptr_q + 8'h01;
						end
						else
						begin
							bitCnt_d = bitCnt_q + 4'h1;
							shift_d  = {shift_q[6:0], 1'b0};
							sdaLow_d = ~shift_q[6];
						end
					end
				end
				D_RACK:
				begin
					// Low means more data wanted; high ends the read
					if (sclRise)
					begin
						state_d    = D_RLOAD;
						waitStop_d = sda;
					end
				end
				default:
				begin
					state_d = D_IDLE;
				end
			endcase
		end
	end

	// State registers
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q    <= D_IDLE;
			next_q     <= D_IDLE;
			waitStop_q <= 1'b0;
			bitCnt_q   <= 4'h0;
			shift_q    <= 8'h00;
			sdaLow_q   <= 1'b0;
			ptr_q      <= 8'h00;
			ptrDef_q   <= 1'b0;
			readLike_q <= 1'b0;
			busyCnt_q  <= 20'h00000;
			pageMask_q <= 8'h00;
			for (int i = 0; i < PAGE_WORDS; i++)
				page_q[i] <= 8'h00;
			for (int i = 0; i < MEM_WORDS; i++)
				mem_q[i] <= MEM_RESET_VALUE;
		end
		else
		begin
			state_q    <= state_d;
			next_q     <= next_d;
			waitStop_q <= waitStop_d;
			bitCnt_q   <= bitCnt_d;
			shift_q    <= shift_d;
			sdaLow_q   <= sdaLow_d;
			ptr_q      <= ptr_d;
			ptrDef_q   <= ptrDef_d;
			readLike_q <= readLike_d;
			busyCnt_q  <= busyCnt_d;
			pageMask_q <= pageMask_d;
			page_q     <= page_d;
			mem_q      <= mem_d;
		end
	end

	// Open-drain output: only ever pulls low
	assign bus.devSdaOut  = 1'b0;
	assign bus.devSdaOe   = sdaLow_q;
	assign writeBusy      = busyCnt_q != 20'h00000;
	assign pointerDefined = ptrDef_q;
endmodule : eeprom_target

// >>> src/eeprom_controller.sv
// Two-wire bus controller with Avalon-MM command and status registers
`timescale 1ns/1ps
module eeprom_controller
	import eeprom_pkg::*;
#(
	parameter int QUARTER = QUARTER_CYCLES,
	parameter int POWERUP = POWERUP_CYCLES
)
(
	input  wire logic        clock,
	input  wire logic        arst_n,
	i2c_if.host              bus,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest
);
	typedef enum logic [2:0] {
		H_POWER = 3'h0,
		H_IDLE  = 3'h1,
		H_START = 3'h2,
		H_BIT   = 3'h3,
		H_STOP  = 3'h4
	} host_state_t;

	generate
		// Power-up count runs inside one quarter; target needs three clocks of lag per quarter
		if (QUARTER < 4 || QUARTER > 65535 || POWERUP < 1 || POWERUP > QUARTER)
		begin : gBadTiming
			$error("QUARTER or POWERUP out of range");
		end
	endgenerate

	host_state_t st_q;
	host_state_t st_d;
	host_op_t    op_q;
	host_op_t    op_d;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic [1:0]  ph_q;
	logic [1:0]  ph_d;
	logic [3:0]  bit_q;
	logic [3:0]  bit_d;
	logic [8:0]  tx_q;
	logic [8:0]  tx_d;
	logic [8:0]  rx_q;
	logic [8:0]  rx_d;
	logic        seq_q;
	logic        seq_d;
	logic        stale_q;
	logic        stale_d;
	logic        sclHigh_q;
	logic        sclHigh_d;
	logic        sdaLow_q;
	logic        sdaLow_d;
	logic        drvHigh_q;
	logic        drvHigh_d;
	logic        done_q;
	logic        done_d;
	logic [31:0] readdata_d;
	logic [31:0] readdata_q;
	logic [31:0] status;
	logic        sda1_q;
	logic        sda2_q;
	logic        busy;
	logic        stepDone;
	logic        cmdWr;

	// Line level for acknowledge and read data
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sda1_q <= 1'b1;
			sda2_q <= 1'b1;
		end
		else
		begin
			sda1_q <= bus.sdaLine;
			sda2_q <= sda1_q;
		end
	end

	assign busy        = st_q != H_IDLE;
	assign cmdWr       = write && address == REG_COMMAND;
	assign waitrequest = (read | write) & ~done_q;
	assign stepDone    = cnt_q == 16'(QUARTER - 1) && ph_q == 2'h3;

	// Status word
	always_comb
	begin
		status                       = 32'h00000000;
		status[STAT_BUSY_BIT]        = busy;
		status[STAT_ACK_BIT]         = ~rx_q[0];
		status[STAT_STALE_BIT]       = stale_q;
		status[STAT_RX_LSB +: 8]     = rx_q[8:1];
	end

	// Bus slave plus bit-level sequencer
	always_comb
	begin
		st_d       = st_q;
		op_d       = op_q;
		cnt_d      = cnt_q;
		ph_d       = ph_q;
		bit_d      = bit_q;
		tx_d       = tx_q;
		rx_d       = rx_q;
		seq_d      = seq_q;
		stale_d    = stale_q;
		sclHigh_d  = sclHigh_q;
		sdaLow_d   = sdaLow_q;
		drvHigh_d  = drvHigh_q;
		readdata_d = readdata_q;
		// A command waits while a sequence runs; that stall is the back-pressure
		done_d = (read | write) & ~done_q & ~(cmdWr & busy);
		if (done_d)
			readdata_d = (read && address == REG_STATUS) ? status : 32'h00000000;
		if (st_q != H_IDLE)
		begin
			cnt_d = cnt_q + 16'h0001;
			if (cnt_q == 16'(QUARTER - 1))
			begin
				cnt_d = 16'h0000;
				ph_d  = ph_q + 2'h1;
			end
		end
		case (st_q)
			H_POWER:
			begin
				if (cnt_q == 16'(POWERUP - 1))
				begin
					drvHigh_d = 1'b0;
					st_d      = H_START;
					op_d      = OP_SWRESET;
					seq_d     = 1'b0;
					cnt_d     = 16'h0000;
					ph_d      = 2'h0;
				end
			end
			H_IDLE:
			begin
				if (write && done_q && address == REG_COMMAND)
				begin
					op_d  = host_op_t'(writedata[CMD_OP_LSB +: 3]);
					bit_d = 4'h0;
					seq_d = 1'b0;
					cnt_d = 16'h0000;
					ph_d  = 2'h0;
					case (host_op_t'(writedata[CMD_OP_LSB +: 3]))
						OP_START, OP_SWRESET:  st_d = H_START;
						OP_STOP:               st_d = H_STOP;
						OP_ABORT:
						begin
							st_d    = H_START;
							stale_d = 1'b1;
						end
						OP_WRITE:
						begin
							st_d    = H_BIT;
							tx_d    = {writedata[CMD_TX_LSB +: 8], 1'b1};
							stale_d = 1'b0;
						end
						OP_READ:
						begin
							st_d = H_BIT;
							tx_d = {8'hFF, writedata[CMD_NAK_BIT]};
						end
						default:               st_d = H_IDLE;
					endcase
				end
			end
			H_START:
			begin
				sclHigh_d = ph_q == 2'h1 || ph_q == 2'h2;
				sdaLow_d  = ph_q[1];
				if (stepDone)
				begin
					st_d = H_IDLE;
					if (op_q == OP_ABORT)
						st_d = H_STOP;
					else if (op_q == OP_SWRESET && !seq_q)
					begin
						st_d  = H_BIT;
						tx_d  = 9'h1FF;
						bit_d = 4'h0;
						seq_d = 1'b1;
					end
				end
			end
			H_BIT:
			begin
				sclHigh_d = ph_q[1];
				sdaLow_d  = ~tx_q[8];
				if (stepDone)
				begin
					rx_d  = {rx_q[7:0], sda2_q};
					tx_d  = {tx_q[7:0], 1'b1};
					bit_d = bit_q + 4'h1;
					if (bit_q == 4'h8)
						st_d = (op_q == OP_SWRESET) ? H_START : H_IDLE;
				end
			end
			H_STOP:
			begin
				sclHigh_d = ph_q != 2'h0;
				sdaLow_d  = ~ph_q[1];
				if (stepDone)
					st_d = H_IDLE;
			end
			default:
			begin
				st_d = H_IDLE;
			end
		endcase
	end

	// State registers; power-up starts with both lines driven high
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q       <= H_POWER;
			op_q       <= OP_NONE;
			cnt_q      <= 16'h0000;
			ph_q       <= 2'h0;
			bit_q      <= 4'h0;
			tx_q       <= 9'h1FF;
			rx_q       <= 9'h1FF;
			seq_q      <= 1'b0;
			stale_q    <= 1'b0;
			sclHigh_q  <= 1'b1;
			sdaLow_q   <= 1'b0;
			drvHigh_q  <= 1'b1;
			done_q     <= 1'b0;
			readdata_q <= 32'h00000000;
		end
		else
		begin
			st_q       <= st_d;
			op_q       <= op_d;
			cnt_q      <= cnt_d;
			ph_q       <= ph_d;
			bit_q      <= bit_d;
			tx_q       <= tx_d;
			rx_q       <= rx_d;
			seq_q      <= seq_d;
			stale_q    <= stale_d;
			sclHigh_q  <= sclHigh_d;
			sdaLow_q   <= sdaLow_d;
			drvHigh_q  <= drvHigh_d;
			done_q     <= done_d;
			readdata_q <= readdata_d;
		end
	end

	// SCL is push-pull; SDA pulls low, or drives high only at power-up
	assign bus.sclOut     = sclHigh_q;
	assign bus.sclOe      = 1'b1;
	assign bus.hostSdaOut = drvHigh_q;
	assign bus.hostSdaOe  = sdaLow_q | drvHigh_q;
	assign readdata       = readdata_q;
endmodule : eeprom_controller

// >>> testbench/eeprom_props.sv
// Concurrent checks on the two-wire bus between controller and EEPROM target
`timescale 1ns/1ps
module eeprom_props
	import eeprom_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic sclLine,
	input wire logic sdaLine,
	input wire logic devSdaOe,
	input wire logic chipSelectStrapBit0,
	input wire logic chipSelectStrapBit1,
	input wire logic chipSelectStrapBit2,
	input wire logic writeGuard,
	input wire logic lowSupplyWriteLockout,
	input wire logic writeBusy,
	input wire logic pointerDefined
);
	logic       sclQ;
	logic       sdaQ;
	logic [7:0] shiftQ;
	logic [7:0] cntQ;
	logic       wrMatchQ;
	logic       wordQ;
	logic       sclRise;
	logic       startEv;
	logic       stopEv;
	logic       ackRise;
	logic       addrHit;
	logic       abortStop;

	// Bus events from one-cycle-old line levels
	assign sclRise   = sclLine & ~sclQ;
	assign startEv   = sclLine & sclQ & sdaQ & ~sdaLine;
	assign stopEv    = sclLine & sclQ & ~sdaQ & sdaLine;
	assign ackRise   = sclRise & (cntQ == 8'h08);
	assign addrHit   = shiftQ[7:1] == {DEVICE_TYPE_CODE, chipSelectStrapBit2,
		chipSelectStrapBit1, chipSelectStrapBit0};
	assign abortStop = stopEv & (cntQ < 8'h09);

	// Bit count since START; saturates so long reads never wrap into the address phase
	always_ff @(posedge clock or negedge arst_n)
		if (!arst_n)
		begin
			sclQ     <= 1'b1;
			sdaQ     <= 1'b1;
			shiftQ   <= 8'h00;
			cntQ     <= 8'hFF;
			wrMatchQ <= 1'b0;
			wordQ    <= 1'b0;
		end
		else
		begin
			sclQ <= sclLine;
			sdaQ <= sdaLine;
			if (startEv)
				cntQ <= 8'h00;
			else if (sclRise && cntQ != 8'hFF)
				cntQ <= cntQ + 8'h01;
			if (sclRise)
				shiftQ <= {shiftQ[6:0], sdaLine};
			if (ackRise)
				wrMatchQ <= addrHit & ~shiftQ[0] & ~sdaLine;
			if (sclRise && cntQ == 8'h11 && wrMatchQ)
				wordQ <= 1'b1;
			else if (stopEv || (sclRise && cntQ == 8'h1A)) // A data byte makes it a write
				wordQ <= 1'b0;
		end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence staysIdle;
		!writeBusy [*8];
	endsequence
	sequence commitSoon;
		##[1:8] writeBusy;
	endsequence

	abort_no_commit_a : assert property (abortStop && !writeBusy |=> staysIdle)
		else $error("abort started a write");
	sda_drive_edge_a : assert property ($changed(devSdaOe) |-> !sclLine)
		else $error("target changed SDA with SCL high");
	strap_nak_a : assert property (ackRise && !addrHit |-> sdaLine)
		else $error("foreign address acknowledged");
	addr_ack_a : assert property (ackRise && addrHit && !writeBusy
		&& !$past(writeBusy, 32) |-> !sdaLine)
		else $error("own address not acknowledged");
	busy_nak_a : assert property (ackRise && writeBusy && $past(writeBusy, 32) |-> sdaLine)
		else $error("busy target acknowledged");
	guard_blocks_a : assert property (stopEv && writeGuard && !writeBusy |=> staysIdle)
		else $error("guarded write committed");
	guard_low_write_a : assert property (stopEv && cntQ > 8'h1A && wrMatchQ && !writeGuard
		&& !lowSupplyWriteLockout && !writeBusy |-> commitSoon)
		else $error("open write not committed");
	pointer_lost_a : assert property (abortStop && wordQ |-> ##[1:8] !pointerDefined)
		else $error("pointer still valid after abort");
endmodule : eeprom_props

// >>> testbench/tb_top.sv
// Self-checking bench: controller and EEPROM target joined over the two-wire carrier
`timescale 1ns/1ps
module tb_top
	import eeprom_pkg::*;
;
	localparam int         WR_CYC   = 2000;
	localparam int         LIMIT    = 20000;
	localparam logic [2:0] MY_STRAP = 3'h5;
	logic        clock;
	logic        arst_n;
	logic [2:0]  strap;
	logic        writeGuard;
	logic        lowSupplyWriteLockout;
	logic        writeBusy;
	logic        pointerDefined;
	logic [3:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [31:0] st;
	logic [7:0]  rd;
	int          fail_count;
	int          n_tests;

	i2c_if bus ();

	eeprom_target #(.WRITE_CYCLES(WR_CYC)) u_eeprom_target (
		.clock                 (clock),
		.arst_n                (arst_n),
		.bus                   (bus),
		.chipSelectStrapBit0   (strap[0]),
		.chipSelectStrapBit1   (strap[1]),
		.chipSelectStrapBit2   (strap[2]),
		.writeGuard            (writeGuard),
		.lowSupplyWriteLockout (lowSupplyWriteLockout),
		.writeBusy             (writeBusy),
		.pointerDefined        (pointerDefined)
	);

	eeprom_controller #(.QUARTER(4), .POWERUP(4)) u_eeprom_controller (
		.clock       (clock),
		.arst_n      (arst_n),
		.bus         (bus),
		.address     (address),
		.read        (read),
		.write       (write),
		.writedata   (writedata),
		.readdata    (readdata),
		.waitrequest (waitrequest)
	);

	eeprom_props u_eeprom_props (
		.clock                 (clock),
		.arst_n                (arst_n),
		.sclLine               (bus.sclLine),
		.sdaLine               (bus.sdaLine),
		.devSdaOe              (bus.devSdaOe),
		.chipSelectStrapBit0   (strap[0]),
		.chipSelectStrapBit1   (strap[1]),
		.chipSelectStrapBit2   (strap[2]),
		.writeGuard            (writeGuard),
		.lowSupplyWriteLockout (lowSupplyWriteLockout),
		.writeBusy             (writeBusy),
		.pointerDefined        (pointerDefined)
	);

	// Free-running system clock
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic tally_and_finish;
		$display("Comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	task automatic give_up;
		fail_count++;
		tally_and_finish;
	endtask : give_up

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One Avalon transfer; request held until waitrequest is seen low
	task automatic bus_access(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		address   <= a;
		writedata <= d;
		read      <= ~wr;
		write     <= wr;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (waitrequest !== 1'b0 && n < LIMIT);
		if (waitrequest !== 1'b0)
			give_up;
		st = readdata;
		read  <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask : bus_access

	// Poll status until the controller reports idle
	task automatic wait_idle;
		int n;
		n = 0;
		do
		begin
			bus_access(1'b0, REG_STATUS, 32'h0);
			n++;
		end
		while (st[STAT_BUSY_BIT] !== 1'b0 && n < LIMIT);
		if (st[STAT_BUSY_BIT] !== 1'b0)
			give_up;
	endtask : wait_idle

	task automatic op(input host_op_t o, input logic [7:0] tx, input logic nak);
		bus_access(1'b1, REG_COMMAND, {15'h0000, nak, tx, 5'h00, o});
		wait_idle;
	endtask : op

	function automatic logic [7:0] dev(input logic [2:0] s, input logic rw);
		return {DEVICE_TYPE_CODE, s, rw};
	endfunction : dev

	task automatic send(input logic [7:0] b, input logic expAck);
		op(OP_WRITE, b, 1'b0);
		check({31'h0, st[STAT_ACK_BIT]}, {31'h0, expAck});
	endtask : send

	task automatic write_mem(input logic [7:0] w, input logic [7:0] d);
		op(OP_START, 8'h00, 1'b0);
		send(dev(MY_STRAP, 1'b0), 1'b1);
		send(w, 1'b1);
		send(d, 1'b1);
		op(OP_STOP, 8'h00, 1'b0);
	endtask : write_mem

	// Random read of one byte, ended by a NAK and STOP
	task automatic read_mem(input logic [7:0] w);
		op(OP_START, 8'h00, 1'b0);
		send(dev(MY_STRAP, 1'b0), 1'b1);
		send(w, 1'b1);
		op(OP_START, 8'h00, 1'b0);
		send(dev(MY_STRAP, 1'b1), 1'b1);
		op(OP_READ, 8'h00, 1'b1);
		rd = st[STAT_RX_LSB +: 8];
		op(OP_STOP, 8'h00, 1'b0);
	endtask : read_mem

	task automatic wait_ready;
		int n;
		n = 0;
		while (writeBusy !== 1'b0 && n < LIMIT)
		begin
			@(posedge clock);
			n++;
		end
		if (writeBusy !== 1'b0)
			give_up;
	endtask : wait_ready

	// Main sequence
	initial
	begin
		arst_n <= 1'b0;
		strap <= MY_STRAP;
		writeGuard <= 1'b0;
		lowSupplyWriteLockout <= 1'b0;
		address <= 4'h0;
		read <= 1'b0;
		write <= 1'b0;
		writedata <= 32'h0;
		fail_count = 0;
		n_tests = 0;
		repeat (16) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		check({31'h0, pointerDefined}, 32'h0);
		wait_idle;
		// Every strap code against one fixed address byte
		for (int i = 0; i < 8; i++)
		begin
			strap <= 3'(i);
			op(OP_START, 8'h00, 1'b0);
			send(dev(MY_STRAP, 1'b0), 3'(i) == MY_STRAP);
			op(OP_STOP, 8'h00, 1'b0);
		end
		strap <= MY_STRAP;
		write_mem(8'h12, 8'h5A);
		check({31'h0, writeBusy}, 32'h1);
		op(OP_START, 8'h00, 1'b0);
		send(dev(MY_STRAP, 1'b0), 1'b0);
		op(OP_STOP, 8'h00, 1'b0);
		wait_ready;
		read_mem(8'h12);
		check({24'h0, rd}, 32'h5A);
		check({31'h0, pointerDefined}, 32'h1);
		// Guard, then supply lockout, must drop the write; reads still work under guard
		for (int k = 0; k < 2; k++)
		begin
			writeGuard <= (k == 0);
			lowSupplyWriteLockout <= (k == 1);
			write_mem(8'h12, 8'hA5);
			check({31'h0, writeBusy}, 32'h0);
			read_mem(8'h12);
			check({24'h0, rd}, 32'h5A);
		end
		// Cleared once, after the loop, so no signal gets two drives in one step
		lowSupplyWriteLockout <= 1'b0;
		// Abort after a data byte: nothing may be programmed
		op(OP_START, 8'h00, 1'b0);
		send(dev(MY_STRAP, 1'b0), 1'b1);
		send(8'h20, 1'b1);
		send(8'h33, 1'b1);
		op(OP_ABORT, 8'h00, 1'b0);
		check({31'h0, st[STAT_STALE_BIT]}, 32'h1);
		check({31'h0, writeBusy}, 32'h0);
		read_mem(8'h20);
		check({31'h0, st[STAT_STALE_BIT]}, 32'h0);
		check({24'h0, rd}, {24'h0, MEM_RESET_VALUE});
		// Abort inside a random read loses the pointer
		op(OP_START, 8'h00, 1'b0);
		send(dev(MY_STRAP, 1'b0), 1'b1);
		send(8'h12, 1'b1);
		op(OP_ABORT, 8'h00, 1'b0);
		check({31'h0, pointerDefined}, 32'h0);
		read_mem(8'h12);
		check({24'h0, rd}, 32'h5A);
		// Target left driving zeros; only the dummy-clock reset frees the bus
		write_mem(8'h30, 8'h00);
		wait_ready;
		op(OP_START, 8'h00, 1'b0);
		send(dev(MY_STRAP, 1'b0), 1'b1);
		send(8'h30, 1'b1);
		op(OP_START, 8'h00, 1'b0);
		send(dev(MY_STRAP, 1'b1), 1'b1);
		op(OP_SWRESET, 8'h00, 1'b0);
		op(OP_STOP, 8'h00, 1'b0);
		read_mem(8'h30);
		check({24'h0, rd}, 32'h00);
		tally_and_finish;
	end
endmodule : tb_top
